// *** rcf_pkg.sv ***
// Purpose: Shared constants and types of the rolling code transmit framer.
// Assumes: 40 MHz system clock, byte-addressed register port of 32-bit words.
// Notes:   Times are kept in their own units; cycle counts derive from them.
package rcf_pkg;

  // Clock and times
  localparam int unsigned CLK_HZ       = 40_000_000;
  localparam int unsigned DEBOUNCE_MS  = 30;
  localparam int unsigned DEBOUNCE_CYC = (CLK_HZ / 1000) * DEBOUNCE_MS;
  localparam int unsigned REPRESS_S    = 2;
  localparam int unsigned REPRESS_CYC  = CLK_HZ * REPRESS_S;
  localparam int unsigned TIMEOUT_S    = 20;
  localparam int unsigned TIMEOUT_CYC  = CLK_HZ * TIMEOUT_S;
  localparam int unsigned TE_US        = 200;
  localparam int unsigned TE_CYC       = (CLK_HZ / 1_000_000) * TE_US;

  // Frame shape in base symbol periods
  localparam int unsigned PREAMBLE_TE  = 23;
  localparam int unsigned HEADER_TE    = 10;
  localparam int unsigned GUARD_TE     = 39;
  localparam int unsigned PWM_BIT_TE   = 3;
  localparam int unsigned PWM_ONE_HI   = 1;
  localparam int unsigned PWM_ZERO_HI  = 2;
  localparam int unsigned MAN_BIT_TE   = 2;

  // Code word layout, bit 0 leaves first
  localparam int unsigned WORD_W     = 69;
  localparam int unsigned HOP_W      = 32;
  localparam int unsigned SERIAL_LSB = 32;
  localparam int unsigned FUNC_LSB   = 60;
  localparam int unsigned BATTERY_LOW_FLAG_BIT   = 64;
  localparam int unsigned CRC_LSB    = 65;
  localparam int unsigned QUE_LSB    = 67;
  localparam int unsigned CRC_SPAN   = 65;
  localparam int unsigned HOP_ROUNDS = 64;

  // Register byte offsets
  localparam logic [5:0] OFF_CTRL    = 6'h00;
  localparam logic [5:0] OFF_SERIAL  = 6'h04;
  localparam logic [5:0] OFF_DISC    = 6'h08;
  localparam logic [5:0] OFF_SYNC    = 6'h0c;
  localparam logic [5:0] OFF_KEY_LO  = 6'h10;
  localparam logic [5:0] OFF_KEY_HI  = 6'h14;
  localparam logic [5:0] OFF_SEED_LO = 6'h18;
  localparam logic [5:0] OFF_SEED_HI = 6'h1c;
  localparam logic [5:0] OFF_STATUS  = 6'h20;
  localparam logic [5:0] OFF_PROG    = 6'h24;

  // Reset values
  localparam logic [31:0] SERIAL_RST = 32'h0000_0000;
  localparam logic [15:0] SYNC_RST   = 16'h0000;

  typedef enum logic [3:0] {
    ST_IDLE, ST_DEBOUNCE, ST_BUILD, ST_PREAMBLE, ST_HEADER,
    ST_LEAD, ST_DATA, ST_TRAIL, ST_GUARD, ST_HOLD
  } rcf_state_t;

  // Control register, high bits first
  typedef struct packed {
    logic       coil_clamp;
    logic [1:0] overflow;
    logic       temporary_learn_window;
    logic       seed_en;
    logic [1:0] baud_sel;
    logic       ext_serial;
    logic       biphase_select;
  } rcf_cfg_t;

  typedef struct packed {
    logic [5:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } rcf_bus_req_t;

endpackage : rcf_pkg

// *** rcf_framer.sv ***
// Purpose: Rolling code transmit framer of a keyfob encoder.
// Assumes: Pins arrive asynchronously; one 40 MHz clock; word register port.
// Notes:   The keyed mixer stands in for the real cipher core.
// Overview of operation
// [R01] Coil low plus switches starts transmission
// [R02] Wake, debounce 30 ms, then sample
// [R03] Encrypt counter, fixed and switch data
// [R04] Held switches resend same word with guard
// [R05] Counter advances; overflow bits sent
// [R06] Added switch aborts word immediately
// [R07] Full release finishes word, powers down
// [R08] Same combination within 2 s restarts
// [R09] Preamble, header, 32 hop, 37 fixed
// [R10] Guard idle after every word
// [R11] Plaintext: function, overflow, discrimination, counter
// [R12] Clear part: queue, check, battery, function, serial
// [R13] Extended serial replaces clear function bits
// [R14] Least significant bit leaves first
// [R15] Configurable pulse width or biphase coding
// [R16] Biphase adds leading and closing one
// [R17] All durations multiples of base period
// [R18] Programming mode: data and clock pins
// [R19] Coil send by clamping, receive detector
// [R20] Check bits over 65 bits, start zero
// [R21] Check bit update equations
// [R22] Frame lengths are design parameters
`timescale 1ns/10ps
`default_nettype none

module rcf_framer
  import rcf_pkg::*;
#(
  parameter int unsigned P_DEBOUNCE_CYC = DEBOUNCE_CYC,
  parameter int unsigned P_REPRESS_CYC  = REPRESS_CYC,
  parameter int unsigned P_TIMEOUT_CYC  = TIMEOUT_CYC,
  parameter int unsigned P_TE_CYC       = TE_CYC,
  parameter int unsigned P_PREAMBLE_TE  = PREAMBLE_TE,
  parameter int unsigned P_HEADER_TE    = HEADER_TE,
  parameter int unsigned P_GUARD_TE     = GUARD_TE,
  parameter int unsigned P_PWM_BIT_TE   = PWM_BIT_TE,
  parameter int unsigned P_PWM_ONE_HI   = PWM_ONE_HI,
  parameter int unsigned P_PWM_ZERO_HI  = PWM_ZERO_HI
) (
  input  wire logic         clk_sys,
  input  wire logic         arst_n,
  input  wire rcf_bus_req_t bus_req,
  output logic [31:0]       bus_rdata,
  input  wire logic         switch_in_0,
  input  wire logic         switch_in_1,
  input  wire logic         switch_in_2_lamp_out_in,
  output logic              switch_in_2_lamp_out_out,
  output logic              switch_in_2_lamp_out_oe_n,
  input  wire logic         coil_pin_a_in,
  output logic              coil_pin_a_out,
  output logic              coil_pin_a_oe_n,
  input  wire logic         coil_pin_b_in,
  output logic              coil_pin_b_out,
  output logic              coil_pin_b_oe_n,
  input  wire logic         data_pin_in,
  output logic              data_pin_out,
  output logic              data_pin_oe_n,
  input  wire logic         battery_low_flag,
  input  wire logic         prog_mode_in,
  output logic              tx_busy
);

  // Refuse shapes the counters cannot hold
  if (P_TE_CYC < 1 || P_TE_CYC * 8 > 65535 || P_PREAMBLE_TE < 1 ||
      P_HEADER_TE < 1 || P_GUARD_TE < 1 || P_PWM_BIT_TE < 2 ||
      P_PWM_ONE_HI >= P_PWM_BIT_TE || P_PWM_ZERO_HI >= P_PWM_BIT_TE ||
      P_PREAMBLE_TE > 65535 || P_GUARD_TE > 65535 || P_HEADER_TE > 65535 ||
      P_DEBOUNCE_CYC < 1 || P_REPRESS_CYC < 1 || P_TIMEOUT_CYC < 1)
  begin : g_bad_param
    $error("rcf_framer: unsupported parameter values");
  end

  typedef struct packed {
    rcf_state_t  fsm;
    logic [6:0]  meta;
    logic [6:0]  pin;
    logic        sck_d;
    logic [31:0] prog_sh;
    rcf_cfg_t    cfg;
    logic [31:0] serial;
    logic [9:0]  disc;
    logic [15:0] sync;
    logic [63:0] key;
    logic [59:0] seed;
    logic [31:0] rdata;
    logic [2:0]  func;
    logic        released;
    logic [1:0]  repeat_press_count;
    logic        seed_mode;
    logic        seed_pend;
    logic [68:0] word;
    logic [31:0] timer;
    logic [31:0] win;
    logic [31:0] life;
    logic [15:0] te_div;
    logic [15:0] seg;
    logic [6:0]  bit_idx;
    logic        tx_lvl;
  } rcf_st_t;

  rcf_st_t st_r;
  rcf_st_t st_nxt;

  // Keyed nonlinear mixer: any plaintext bit change spreads over the output
  function automatic logic [31:0] hop_mix(input logic [31:0] p,
                                          input logic [63:0] k);
    logic [31:0] x;
    logic        f;
    x = p;
    for (int i = 0; i < HOP_ROUNDS; i++) begin
      f = (x[1] & x[9]) ^ (x[20] | x[26]) ^ x[31];
      x = {f ^ x[0] ^ x[16] ^ k[i % 64], x[31:1]};
    end
    return x;
  endfunction : hop_mix

  // Serial check over the bits sent ahead of the check field
  function automatic logic [1:0] crc_of(input logic [68:0] w);
    logic [1:0] c;
    logic       d;
    c = 2'b00;                                            // R20
    for (int i = 0; i < CRC_SPAN; i++) begin
      d = c[0] ^ w[i];
      c = {d, d ^ c[1]};                                  // R21
    end
    return c;
  endfunction : crc_of

  // Element length in base periods
  function automatic logic [15:0] elem_len(input rcf_state_t s,
                                           input logic man);
    case (s)
      ST_PREAMBLE: return 16'(P_PREAMBLE_TE);             // R22
      ST_HEADER:   return 16'(P_HEADER_TE);
      ST_GUARD:    return 16'(P_GUARD_TE);
      ST_DATA:     return man ? 16'(MAN_BIT_TE) : 16'(P_PWM_BIT_TE);
      default:     return 16'(MAN_BIT_TE);
    endcase
  endfunction : elem_len

  // Line level for one base period of an element
  function automatic logic lvl_of(input rcf_state_t s, input logic [15:0] g,
                                  input logic b, input logic man);
    case (s)
      ST_PREAMBLE:      return ~g[0];
      ST_LEAD, ST_TRAIL: return g != 16'h0000;            // R16
      ST_DATA: begin
        if (man) begin
          return b ? (g != 16'h0000) : (g == 16'h0000);   // R15
        end
        return g < (b ? 16'(P_PWM_ONE_HI) : 16'(P_PWM_ZERO_HI));
      end
      default:          return 1'b0;
    endcase
  endfunction : lvl_of

  logic [2:0]  sw;
  logic        sending;
  logic        tick;
  logic        elem_end;
  logic [15:0] te_len;
  logic        seed_ok;
  logic        transponder;
  logic [31:0] plain;
  logic [68:0] new_word;

  assign sw          = st_r.pin[2:0];
  assign transponder = st_r.pin[3] && (sw == 3'b000);     // R01
  assign sending     = st_r.fsm inside {ST_PREAMBLE, ST_HEADER, ST_LEAD,
                                        ST_DATA, ST_TRAIL, ST_GUARD};
  // Base period scales by powers of two with the baud select
  assign te_len   = 16'(P_TE_CYC) << st_r.cfg.baud_sel;   // R17
  assign tick     = st_r.te_div == te_len - 16'h0001;
  assign elem_end = tick &&
                    st_r.seg == elem_len(st_r.fsm, st_r.cfg.biphase_select) -
                    16'h0001;
  assign seed_ok  = st_r.cfg.seed_en && st_r.cfg.temporary_learn_window;

  // Plaintext and the finished word
  assign plain = {{1'b0, st_r.func}, st_r.cfg.overflow, st_r.disc,
                  st_r.sync};                             // R11 R05
  always_comb begin
    new_word = '0;
    if (st_r.seed_mode) begin
      new_word[59:0] = st_r.seed;
      new_word[FUNC_LSB +: 4] = {1'b0, st_r.func};
    end else begin
      new_word[HOP_W-1:0] = hop_mix(plain, st_r.key);     // R03
      if (st_r.cfg.ext_serial) begin
        new_word[SERIAL_LSB +: 32] = st_r.serial;         // R13
      end else begin
        new_word[SERIAL_LSB +: 28] = st_r.serial[27:0];   // R12
        new_word[FUNC_LSB +: 4] = {1'b0, st_r.func};
      end
    end
    new_word[BATTERY_LOW_FLAG_BIT]      = st_r.pin[4];
    new_word[QUE_LSB +: 2]  = st_r.repeat_press_count;
    new_word[CRC_LSB +: 2]  = crc_of(new_word);           // R20
  end

  // Next state of the whole block
  always_comb begin
    st_nxt       = st_r;
    st_nxt.meta  = {data_pin_in, prog_mode_in, battery_low_flag,
                    coil_pin_a_in, switch_in_2_lamp_out_in, switch_in_1,
                    switch_in_0};
    st_nxt.pin   = st_r.meta;
    st_nxt.rdata = 32'h0000_0000;

    // Register writes
    if (bus_req.wr) begin
      case (bus_req.addr)
        OFF_CTRL:    st_nxt.cfg = bus_req.wdata[8:0];
        OFF_SERIAL:  st_nxt.serial = bus_req.wdata;
        OFF_DISC:    st_nxt.disc = bus_req.wdata[9:0];
        OFF_SYNC:    st_nxt.sync = bus_req.wdata[15:0];
        OFF_KEY_LO:  st_nxt.key[31:0] = bus_req.wdata;
        OFF_KEY_HI:  st_nxt.key[63:32] = bus_req.wdata;
        OFF_SEED_LO: st_nxt.seed[31:0] = bus_req.wdata;
        OFF_SEED_HI: st_nxt.seed[59:32] = bus_req.wdata[27:0];
        default:     st_nxt.cfg = st_r.cfg;
      endcase
    end

    // Register reads, data one cycle later; unmapped reads zero
    if (bus_req.rd) begin
      case (bus_req.addr)
        OFF_CTRL:    st_nxt.rdata = {23'h000000, st_r.cfg};
        OFF_SERIAL:  st_nxt.rdata = st_r.serial;
        OFF_DISC:    st_nxt.rdata = {22'h000000, st_r.disc};
        OFF_SYNC:    st_nxt.rdata = {16'h0000, st_r.sync};
        OFF_KEY_LO:  st_nxt.rdata = st_r.key[31:0];
        OFF_KEY_HI:  st_nxt.rdata = st_r.key[63:32];
        OFF_SEED_LO: st_nxt.rdata = st_r.seed[31:0];
        OFF_SEED_HI: st_nxt.rdata = {4'h0, st_r.seed[59:32]};
        OFF_STATUS:  st_nxt.rdata = {21'h000000, st_r.seed_mode,
                                     st_r.pin[4], st_r.pin[3], st_r.repeat_press_count,
                                     transponder, sending, st_r.fsm};
        OFF_PROG:    st_nxt.rdata = st_r.prog_sh;
        default:     st_nxt.rdata = 32'h0000_0000;
      endcase
    end

    // Programming mode shifts the data pin on each rising clock pin
    st_nxt.sck_d = st_r.pin[2];
    if (st_r.pin[5] && st_r.pin[2] && !st_r.sck_d) begin
      st_nxt.prog_sh = {st_r.prog_sh[30:0], st_r.pin[6]};  // R18
    end

    // Free counters: base period divider, window, activation life
    st_nxt.te_div = tick ? 16'h0000 : st_r.te_div + 16'h0001;
    if (st_r.win != 32'h0000_0000) begin
      st_nxt.win = st_r.win - 32'h0000_0001;
    end else if (st_r.fsm == ST_IDLE) begin
      st_nxt.repeat_press_count = 2'b00;
    end
    if (st_r.life != 32'h0000_0000) begin
      st_nxt.life = st_r.life - 32'h0000_0001;
    end
    if (tick) begin
      st_nxt.seg = elem_end ? 16'h0000 : st_r.seg + 16'h0001;
    end
    st_nxt.tx_lvl = sending &&
                    lvl_of(st_r.fsm, st_r.seg, st_r.word[st_r.bit_idx],
                           st_r.cfg.biphase_select);

    case (st_r.fsm)
      ST_IDLE: begin
        // Wake on a closure unless the coil field or programming holds us
        if (sw != 3'b000 && !st_r.pin[3] && !st_r.pin[5]) begin  // R01
          st_nxt.fsm   = ST_DEBOUNCE;
          st_nxt.timer = P_DEBOUNCE_CYC;                  // R02
        end
      end
      ST_DEBOUNCE: begin
        if (st_r.timer != 32'h0000_0000) begin
          st_nxt.timer = st_r.timer - 32'h0000_0001;
        end else if (sw == 3'b000 || st_r.pin[3]) begin
          st_nxt.fsm = ST_IDLE;
        end else begin
          // A repeat of the same combination inside the window queues
          if (st_r.win != 32'h0000_0000 && sw == st_r.func) begin
            st_nxt.repeat_press_count = (st_r.repeat_press_count == 2'b11) ? 2'b11 : st_r.repeat_press_count + 2'b01;
          end else begin
            st_nxt.repeat_press_count = 2'b00;
            st_nxt.win = P_REPRESS_CYC;                   // R08
          end
          st_nxt.func      = sw;
          st_nxt.released  = 1'b0;
          st_nxt.life      = P_TIMEOUT_CYC;
          st_nxt.sync      = st_r.sync + 16'h0001;        // R05
          st_nxt.seed_mode = (sw == 3'b111) && seed_ok;   // R01
          st_nxt.seed_pend = (sw == 3'b011) && seed_ok;
          st_nxt.fsm       = ST_BUILD;
        end
      end
      ST_BUILD: begin
        st_nxt.word    = new_word;
        st_nxt.bit_idx = 7'h00;
        st_nxt.seg     = 16'h0000;
        st_nxt.te_div  = 16'h0000;
        st_nxt.fsm     = ST_PREAMBLE;                     // R09
      end
      ST_HOLD: begin
        if (sw == 3'b000) begin
          st_nxt.fsm = ST_IDLE;
        end
      end
      default: begin
        if (sw == 3'b000) begin
          st_nxt.released = 1'b1;
        end
        if ((sw & ~st_r.func) != 3'b000) begin
          st_nxt.fsm = ST_IDLE;                           // R06
        end else if (st_r.released && sw == st_r.func &&
                     st_r.win != 32'h0000_0000) begin
          st_nxt.fsm   = ST_DEBOUNCE;                     // R08
          st_nxt.timer = P_DEBOUNCE_CYC;
        end else if (elem_end) begin
          case (st_r.fsm)
            ST_PREAMBLE: st_nxt.fsm = ST_HEADER;
            ST_HEADER: begin
              st_nxt.bit_idx = 7'h00;                     // R14
              st_nxt.fsm = st_r.cfg.biphase_select ? ST_LEAD : ST_DATA;
            end
            ST_LEAD:     st_nxt.fsm = ST_DATA;            // R16
            ST_DATA: begin
              if (st_r.bit_idx == 7'(WORD_W - 1)) begin
                st_nxt.fsm = st_r.cfg.biphase_select ? ST_TRAIL : ST_GUARD;
              end else begin
                st_nxt.bit_idx = st_r.bit_idx + 7'h01;    // R14
              end
            end
            ST_TRAIL:    st_nxt.fsm = ST_GUARD;           // R10
            default: begin
              // End of guard: power down, time out, or send again
              if (sw == 3'b000) begin
                st_nxt.fsm = ST_IDLE;                     // R07
              end else if (st_r.life == 32'h0000_0000) begin
                st_nxt.fsm = ST_HOLD;
              end else if (st_r.seed_pend) begin
                st_nxt.seed_pend = 1'b0;
                st_nxt.seed_mode = 1'b1;
                st_nxt.fsm       = ST_BUILD;
              end else begin
                st_nxt.fsm = ST_PREAMBLE;                 // R04
              end
            end
          endcase
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_r        <= '0;
      st_r.fsm    <= ST_IDLE;
      st_r.serial <= SERIAL_RST;
      st_r.sync   <= SYNC_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Pins: data line released in programming mode; coil pins clamp together
  assign bus_rdata                 = st_r.rdata;
  assign data_pin_out              = st_r.tx_lvl;
  assign data_pin_oe_n             = st_r.pin[5];         // R18
  assign switch_in_2_lamp_out_out  = 1'b0;
  assign switch_in_2_lamp_out_oe_n = 1'b1;
  assign coil_pin_a_out            = 1'b0;
  assign coil_pin_b_out            = 1'b0;
  assign coil_pin_a_oe_n           = ~st_r.cfg.coil_clamp; // R19
  assign coil_pin_b_oe_n           = ~st_r.cfg.coil_clamp; // R19
  assign tx_busy                   = sending;

  sequence s_data_start;
    st_r.fsm != ST_DATA ##1 st_r.fsm == ST_DATA;
  endsequence

  a_guard_idle_lvl: assert property (@(posedge clk_sys) // R10
    disable iff (!arst_n) st_r.fsm == ST_GUARD |=> !st_r.tx_lvl)
    else $error("line not idle during guard");
  a_added_switch: assert property (@(posedge clk_sys) // R06
    disable iff (!arst_n)
    (sending && (sw & ~st_r.func) != 3'b000) |=> st_r.fsm == ST_IDLE)
    else $error("added switch did not abort");
  a_debounce_hold: assert property (@(posedge clk_sys) // R02
    disable iff (!arst_n)
    (st_r.fsm == ST_DEBOUNCE && st_r.timer != 32'h0000_0000)
    |=> st_r.fsm == ST_DEBOUNCE)
    else $error("debounce cut short");
  a_sync_advance: assert property (@(posedge clk_sys) // R05
    disable iff (!arst_n)
    (st_r.fsm == ST_DEBOUNCE ##1 st_r.fsm == ST_BUILD && !bus_req.wr)
    |-> st_r.sync == $past(st_r.sync) + 16'h0001)
    else $error("counter did not advance");
  a_crc_field: assert property (@(posedge clk_sys) // R20
    disable iff (!arst_n)
    st_r.fsm == ST_PREAMBLE |-> st_r.word[66:65] == crc_of(st_r.word))
    else $error("check bits wrong");
  a_data_entry: assert property (@(posedge clk_sys) // R14
    disable iff (!arst_n)
    s_data_start |-> st_r.bit_idx == 7'h00 &&
    $past(st_r.fsm) inside {ST_HEADER, ST_LEAD})
    else $error("data did not start at bit zero after header");
  a_word_bound: assert property (@(posedge clk_sys) // R09
    disable iff (!arst_n)
    st_r.fsm == ST_DATA |-> st_r.bit_idx <= 7'(WORD_W - 1))
    else $error("bit index beyond word");
  a_lead_biphase: assert property (@(posedge clk_sys) // R16
    disable iff (!arst_n)
    st_r.fsm inside {ST_LEAD, ST_TRAIL} |-> st_r.cfg.biphase_select)
    else $error("framing one outside biphase");
  a_prog_shift: assert property (@(posedge clk_sys) // R18
    disable iff (!arst_n)
    (st_r.pin[5] && st_r.pin[2] && !st_r.sck_d)
    |=> st_r.prog_sh[0] == $past(st_r.pin[6]))
    else $error("programming bit not shifted in");
  a_coil_pair: assert property (@(posedge clk_sys) // R19
    disable iff (!arst_n)
    coil_pin_a_oe_n == coil_pin_b_oe_n && !coil_pin_a_out)
    else $error("coil pins not clamped together");

endmodule : rcf_framer

`default_nettype wire

// *** rcf_rx_model.sv ***
// Purpose: Receiver model that decodes pulse width frames off the data pin.
// Assumes: Base period of TE_CYC clocks; pulse width coding only.
// Notes:   A long low run means header or guard and restarts the bit count.
`timescale 1ns/10ps
`default_nettype none
module rcf_rx_model #(
  parameter int unsigned TE_CYC = 4
) (
  input  wire logic  clk_sys,
  input  wire logic  arst_n,
  input  wire logic  line_in,
  output logic [68:0] rx_word,
  output logic [7:0]  rx_count
);
  logic        line_r;
  logic [15:0] run_r;
  logic [6:0]  idx_r;
  logic [68:0] shf_r;
  logic        bit_v;
  // Short high pulse is a one, long a zero; slack covers clock jitter
  assign bit_v = (run_r <= 16'(TE_CYC * 3 / 2));
  // Edge timing and bit collection, first bit into position 0
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      line_r   <= 1'b0;
      run_r    <= 16'h0;
      idx_r    <= 7'h0;
      shf_r    <= '0;
      rx_word  <= '0;
      rx_count <= 8'h0;
    end else begin
      line_r <= line_in;
      if (line_in != line_r) run_r <= 16'h1;
      else if (run_r != 16'hffff) run_r <= run_r + 16'h1;
      if (!line_in && line_r) begin
        shf_r[idx_r] <= bit_v;
        idx_r        <= idx_r + 7'h1;
        if (idx_r == 7'd68) begin
          rx_word  <= {bit_v, shf_r[67:0]};
          rx_count <= rx_count + 8'h1;
          idx_r    <= 7'h0;
        end
      end else if (!line_in && run_r == 16'(5 * TE_CYC)) begin
        idx_r <= 7'h0;
      end
    end
  end
endmodule : rcf_rx_model
`default_nettype wire

// *** rcf_framer_tb_top.sv ***
// Purpose: Self-checking bench of the rolling code transmit framer.
// Assumes: Shortened counts; base period of 4 clocks; baud select 0.
// Notes:   Words are judged from the receiver model, never from the design.
`timescale 1ns/10ps
`default_nettype none
module rcf_framer_tb_top
  import rcf_pkg::*;
();
  localparam logic [31:0] SER = 32'h1abcdef1;
  logic clk_sys, arst_n, s0, s1, s2, coil_a, prog, busy, oe_a, oe_b;
  logic data_out, data_oe_n, line;
  logic batt, coil_b, out_a, out_b, lamp_o, lamp_oe, pdat;
  logic [31:0] rdata, d;
  logic [68:0] rx_word, w0, w1;
  logic [7:0] rx_count, n;
  rcf_bus_req_t bus_req;
  int failures, tests_run;
  // Released data line carries the programmer's bit, low at rest
  assign line = (data_oe_n === 1'b0) ? data_out : pdat;
  rcf_framer #(.P_DEBOUNCE_CYC(20), .P_REPRESS_CYC(2000),
    .P_TIMEOUT_CYC(20000), .P_TE_CYC(4)) dut (
    .clk_sys, .arst_n, .bus_req, .bus_rdata(rdata),
    .switch_in_0(s0), .switch_in_1(s1), .switch_in_2_lamp_out_in(s2),
    .switch_in_2_lamp_out_out(lamp_o), .switch_in_2_lamp_out_oe_n(lamp_oe),
    .coil_pin_a_in(coil_a), .coil_pin_a_out(out_a), .coil_pin_a_oe_n(oe_a),
    .coil_pin_b_in(coil_b), .coil_pin_b_out(out_b), .coil_pin_b_oe_n(oe_b),
    .data_pin_in(line), .data_pin_out(data_out), .data_pin_oe_n(data_oe_n),
    .battery_low_flag(batt), .prog_mode_in(prog), .tx_busy(busy));
  rcf_rx_model #(.TE_CYC(4)) rx (.clk_sys, .arst_n, .line_in(line),
    .rx_word, .rx_count);
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [68:0] seen, input logic [68:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_of_test;
    if (failures == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test
  task automatic cyc(input int c);
    repeat (c) @(posedge clk_sys);
  endtask : cyc
  task automatic wr(input logic [5:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    bus_req <= '{a, v, 1'b1, 1'b0};
    @(posedge clk_sys);
    bus_req <= '0;
  endtask : wr
  // Read data stands only in the cycle after the strobe edge
  task automatic rd(input logic [5:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    bus_req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk_sys);
    bus_req <= '0;
    #1 v = rdata;
  endtask : rd
  task automatic wait_busy(input logic v, input int lim);
    for (int i = 0; i < lim && busy !== v; i++) @(posedge clk_sys);
    chk(busy, v);
  endtask : wait_busy
  task automatic get_word(output logic [68:0] w);
    n = rx_count;
    for (int i = 0; i < 3000 && rx_count == n; i++) @(posedge clk_sys);
    chk(rx_count != n, 1'b1);
    w = rx_word;
  endtask : get_word
  function automatic logic [1:0] crc(input logic [68:0] w);
    logic c1, c0, x;
    c1 = 1'b0;
    c0 = 1'b0;
    for (int i = 0; i < 65; i++) begin
      x  = c0 ^ w[i];
      c0 = x ^ c1;
      c1 = x;
    end
    return {c1, c0};
  endfunction : crc
  task automatic chk_word(input logic [68:0] w, input logic [3:0] fn,
                          input logic [1:0] q, input logic ext);
    if (ext) chk(w[63:32], SER);
    else chk(w[63:32], {fn, SER[27:0]});
    chk(w[64], batt);
    chk(w[68:67], q);
    chk(w[66:65], crc(w));
  endtask : chk_word
  // Hang guard sized well beyond the whole sequence
  initial begin
    #1000000;
    failures++;
    end_of_test();
  end
  initial begin
    {arst_n, s0, s1, s2, coil_a, coil_b, prog, pdat} = '0;
    batt = 1'b1;
    bus_req = '0;
    failures = 0;
    tests_run = 0;
    cyc(4);
    arst_n <= 1'b1;
    rd(OFF_SYNC, d);
    chk(d, {16'h0, SYNC_RST});
    rd(OFF_SERIAL, d);
    chk(d, SERIAL_RST);
    rd(6'h3c, d);
    chk(d, 32'h0);
    wr(OFF_SERIAL, SER);
    wr(OFF_DISC, 32'h155);
    wr(OFF_CTRL, 32'h80);
    // Held switch repeats an identical word
    s0 <= 1'b1;
    get_word(w0);
    chk_word(w0, 4'h1, 2'h0, 1'b0);
    get_word(w1);
    chk(w1, w0);
    s0 <= 1'b0;
    wait_busy(1'b0, 3000);
    rd(OFF_SYNC, d);
    chk(d, 32'h1);
    // Quick re-press restarts with queue count one
    cyc(2100);
    wr(OFF_CTRL, 32'h82);
    s1 <= 1'b1;
    wait_busy(1'b1, 100);
    s1 <= 1'b0;
    cyc(40);
    s1 <= 1'b1;
    get_word(w1);
    chk_word(w1, 4'h2, 2'h1, 1'b1);
    chk(w1[31:0] !== w0[31:0], 1'b1);
    s1 <= 1'b0;
    wait_busy(1'b0, 3000);
    // Release in mid data still completes the word; battery reads low
    batt <= 1'b0;
    wr(OFF_CTRL, 32'h80);
    cyc(2100);
    s2 <= 1'b1;
    wait_busy(1'b1, 100);
    cyc(300);
    s2 <= 1'b0;
    get_word(w1);
    chk_word(w1, 4'h4, 2'h0, 1'b0);
    batt <= 1'b1;
    wait_busy(1'b0, 3000);
    // Added switch abandons the word at once
    cyc(2100);
    s0 <= 1'b1;
    wait_busy(1'b1, 100);
    cyc(300);
    n = rx_count;
    s1 <= 1'b1;
    wait_busy(1'b0, 8);
    {s0, s1} <= 2'b00;
    cyc(1200);
    chk(rx_count, n);
    // Field on the coil blocks activation and reads back as transponder
    {coil_a, coil_b} <= 2'b11;
    s0 <= 1'b1;
    cyc(100);
    chk(busy, 1'b0);
    s0 <= 1'b0;
    cyc(5);
    rd(OFF_STATUS, d);
    chk(d, 32'h320);
    {coil_a, coil_b} <= 2'b00;
    // Pattern 111 with learning enabled sends the stored seed
    wr(OFF_SEED_LO, 32'h89abcdef);
    wr(OFF_SEED_HI, 32'h0234567);
    wr(OFF_CTRL, 32'hb0);
    {s0, s1, s2} <= 3'b111;
    get_word(w1);
    chk(w1[59:0], 60'h023456789abcdef);
    chk(w1[63:60], 4'h7);
    chk(w1[66:65], crc(w1));
    {s0, s1, s2} <= 3'b000;
    wait_busy(1'b0, 3000);
    wr(OFF_CTRL, 32'h180);
    cyc(3);
    chk({oe_a, oe_b}, 2'b00);
    chk({out_a, out_b}, 2'b00);
    wr(OFF_CTRL, 32'h80);
    cyc(3);
    chk({oe_a, oe_b}, 2'b11);
    prog <= 1'b1;
    cyc(4);
    chk(data_oe_n, 1'b1);
    chk({lamp_o, lamp_oe}, 2'b01);
    // Clock pin edges shift the data pin in, first bit ends up highest
    for (int i = 3; i >= 0; i--) begin
      pdat <= i[0];
      cyc(2);
      s2 <= 1'b1;
      cyc(3);
      s2 <= 1'b0;
      cyc(2);
    end
    rd(OFF_PROG, d);
    chk(d, 32'ha);
    prog <= 1'b0;
    cyc(4);
    chk(data_oe_n, 1'b0);
    end_of_test();
  end
endmodule : rcf_framer_tb_top
`default_nettype wire
